// [hw/tgb_pkg.sv]
/*
 * tgb_pkg: constants, default load images, enumerations and the buffer
 * entry record type of the timing board initialisation and serial loader.
 * Assumes a 250 MHz system clock; shared by the loader and its bench.
 */
package tgb_pkg;

   // clock and serial timing
   localparam int CLK_PERIOD_PS = 4000;
   localparam int SCK_HALF_NS = 50;
   localparam int SCK_HALF_CYC =
      (SCK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SCK_CNT_BITS = 4;

   // integration unit: one tick period of the external oscillator
   localparam int TICK_PERIOD_MS = 1;
   localparam int MULT_BITS = 8;
   localparam int INT_DEFAULT_TICKS = 10;

   // pixel divider: half period in clock cycles, 1 gives clk/2
   localparam int PIX_HALF_DEFAULT = 1;
   localparam int PIX_CNT_BITS = 8;

   // serial framing
   localparam int WORD_BITS = 16;
   localparam int BIT_CNT_BITS = 4;
   localparam int DLY_CHIPS = 10;
   localparam int BITS_PER_CHIP = 8;
   localparam int DLY_BITS = DLY_CHIPS * BITS_PER_CHIP;
   localparam int DLY_WORDS = DLY_BITS / WORD_BITS;
   localparam int AFE_REGS = 8;
   localparam int AFE_DATA_BITS = 12;
   localparam int AFE_ADDR_BITS = 3;
   localparam int IDX_BITS = 4;

   // chain image, first byte shifted sits at the top: data clock delay,
   // then sample and clamp delays, then horizontal clock delays
   localparam logic [DLY_BITS-1:0] DLY_DEFAULT =
      80'h20_18_18_30_30_10_10_28_28_00;
   // front end register images, register 0 in the low bits
   localparam logic [AFE_REGS*AFE_DATA_BITS-1:0] AFE1_DEFAULT =
      96'h000_000_000_000_010_080_100_001;
   localparam logic [AFE_REGS*AFE_DATA_BITS-1:0] AFE2_DEFAULT =
      96'h000_000_000_000_010_080_100_001;

   // two-entry buffer
   localparam int BUF_DEPTH = 2;

   typedef enum logic [1:0]
   {
      TGB_TGT_DELAY = 2'h0,
      TGB_TGT_AFE1 = 2'h1,
      TGB_TGT_AFE2 = 2'h2
   } tgb_target_t;

   typedef enum logic [2:0]
   {
      TGB_SEQ_START = 3'h0,
      TGB_SEQ_DELAY = 3'h1,
      TGB_SEQ_AFE1 = 3'h2,
      TGB_SEQ_AFE2 = 3'h3,
      TGB_SEQ_DRAIN = 3'h4,
      TGB_SEQ_RUN = 3'h5
   } tgb_seq_t;

   typedef struct packed
   {
      tgb_target_t target;
      logic first;
      logic last;
      logic [WORD_BITS-1:0] data;
   } tgb_entry_t;

endpackage

// [hw/tgb_loader.sv]
/* tgb_loader: board initialisation, default serial loads of the delay
   chain and both front ends, pixel clock divider and integration timer.
   Assumes a free 250 MHz i_clk; inputs other than i_rst and i_ce are pins, synchronised
   here, and undriven control pins are pulled low on the board. */
// Contract
// - Reset or reset button reinitialises the whole board to defaults.
// - Initialisation loads default delays into all ten delay chips serially.
// - Initialisation writes default registers into both front ends serially.
// - Pixel timing divides the master clock, at most half its rate.
// - Each integration tick period is one unit of integration time.
// - Internal integration time is a whole multiple of tick periods.
// - Undriven control lines read zero and all-zero operation works.
// - Operation never needs external control inputs; they only adjust modes.
// - One shared clock and data line, three separate load strobes.
// - Only the selected target's strobe moves; others stay untouched.
// - Chain load shifts eight bits per chip, each byte MSB first.
// - Any chain change rewrites the whole chain in one load.
// - Chain byte order: data clock, sample-clamp, then horizontal delays.
`timescale 1ns/1ps
`default_nettype none

module tgb_loader
#(
   parameter int PIX_HALF_CYC = tgb_pkg::PIX_HALF_DEFAULT,
   parameter int INT_DEFAULT = tgb_pkg::INT_DEFAULT_TICKS
)
(
   // clock, reset, enable
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // pins from outside the clock domain
   input wire logic i_unit_integration_tick,
   input wire logic i_ext_integration,
   input wire logic i_ext_gate,
   input wire logic [tgb_pkg::MULT_BITS-1:0] i_int_mult,
   input wire logic i_reload,
   // serial interface
   output logic o_serial_shift_clock,
   output logic o_serial_shift_data,
   output logic o_delay_chain_load_strobe_n,
   output logic o_front_end_one_load_strobe_n,
   output logic o_front_end_two_load_strobe_n,
   // timing and status
   output logic o_pixel_clock,
   output logic o_integrating,
   output logic o_init_done
);
   typedef struct packed
   {
      // synchronisers: stage 1, stage 2, stage 3 for edges
      logic tick_s1, tick_s2, tick_s3;
      logic mode_s1, mode_s2;
      logic gate_s1, gate_s2;
      logic [tgb_pkg::MULT_BITS-1:0] mult_s1, mult_s2;
      logic rld_s1, rld_s2, rld_s3;
      // sequencer
      tgb_pkg::tgb_seq_t seq;
      logic [tgb_pkg::IDX_BITS-1:0] idx;
      // two-entry buffer
      tgb_pkg::tgb_entry_t [tgb_pkg::BUF_DEPTH-1:0] buf_mem;
      logic wp, rp;
      logic [1:0] cnt;
      // serialiser
      logic busy, closing, phase, last;
      logic [tgb_pkg::SCK_CNT_BITS-1:0] half_cnt;
      logic [tgb_pkg::BIT_CNT_BITS-1:0] bit_cnt;
      logic [tgb_pkg::WORD_BITS-1:0] sh;
      logic sck, sdat;
      logic [2:0] strb_n;
      // run-time timing
      logic [tgb_pkg::PIX_CNT_BITS-1:0] pix_cnt;
      logic pix;
      logic integ;
      logic [tgb_pkg::MULT_BITS-1:0] int_cnt;
      logic done;
   } tgb_state_t;
   tgb_state_t s_q, s_d;
   // strobe bit of a target, used when opening a frame
   function automatic logic [2:0] tgb_sel(input tgb_pkg::tgb_target_t t);
      return 3'h1 << t;
   endfunction
   // build the next state record
   always_comb
   begin
      tgb_pkg::tgb_entry_t w;
      logic push, pop, full, empty, tick_edge, rld_edge;
      logic [tgb_pkg::MULT_BITS-1:0] limit;
      s_d = s_q;
      w = '0;
      limit = (s_q.mult_s2 == '0) ? // zero selects default
         tgb_pkg::MULT_BITS'(INT_DEFAULT) : s_q.mult_s2;
      push = 1'b0;
      full = (s_q.cnt == 2'(tgb_pkg::BUF_DEPTH));
      empty = (s_q.cnt == 2'h0);
      pop = !empty && !s_q.busy && !s_q.closing;
      tick_edge = s_q.tick_s2 && !s_q.tick_s3;
      rld_edge = s_q.rld_s2 && !s_q.rld_s3;
      // two flops on every pin; pulled-low pins read zero
      s_d.tick_s1 = i_unit_integration_tick;
      s_d.tick_s2 = s_q.tick_s1;
      s_d.tick_s3 = s_q.tick_s2;
      s_d.mode_s1 = i_ext_integration;
      s_d.mode_s2 = s_q.mode_s1;
      s_d.gate_s1 = i_ext_gate;
      s_d.gate_s2 = s_q.gate_s1;
      s_d.mult_s1 = i_int_mult;
      s_d.mult_s2 = s_q.mult_s1;
      s_d.rld_s1 = i_reload;
      s_d.rld_s2 = s_q.rld_s1;
      s_d.rld_s3 = s_q.rld_s2;
      // default load sequencer, stalled by a full buffer
      case (s_q.seq)
         tgb_pkg::TGB_SEQ_START:
         begin
            s_d.idx = '0;
            s_d.seq = tgb_pkg::TGB_SEQ_DELAY;
         end
         tgb_pkg::TGB_SEQ_DELAY:
         begin
            // whole chain as one frame, top byte first, MSB first
            w.target = tgb_pkg::TGB_TGT_DELAY;
            w.first = (s_q.idx == '0);
            w.last = (s_q.idx == tgb_pkg::IDX_BITS'(tgb_pkg::DLY_WORDS - 1));
            w.data = tgb_pkg::DLY_DEFAULT[tgb_pkg::DLY_BITS - 1 -
               tgb_pkg::WORD_BITS * int'(s_q.idx) -: tgb_pkg::WORD_BITS];
            push = !full;
            if (push && w.last)
            begin
               s_d.idx = '0;
               s_d.seq = tgb_pkg::TGB_SEQ_AFE1;
            end
            else if (push)
               s_d.idx = s_q.idx + 1'b1;
         end
         tgb_pkg::TGB_SEQ_AFE1, tgb_pkg::TGB_SEQ_AFE2: // frame per register
         begin
            w.target = (s_q.seq == tgb_pkg::TGB_SEQ_AFE1) ?
               tgb_pkg::TGB_TGT_AFE1 : tgb_pkg::TGB_TGT_AFE2;
            w.first = 1'b1;
            w.last = 1'b1;
            w.data = {s_q.idx[tgb_pkg::AFE_ADDR_BITS-1:0], 1'b0,
               (s_q.seq == tgb_pkg::TGB_SEQ_AFE1) ?
               tgb_pkg::AFE1_DEFAULT[tgb_pkg::AFE_DATA_BITS * int'(s_q.idx)
                  +: tgb_pkg::AFE_DATA_BITS] :
               tgb_pkg::AFE2_DEFAULT[tgb_pkg::AFE_DATA_BITS * int'(s_q.idx)
                  +: tgb_pkg::AFE_DATA_BITS]};
            push = !full;
            if (push && s_q.idx ==
               tgb_pkg::IDX_BITS'(tgb_pkg::AFE_REGS - 1))
            begin
               s_d.idx = '0;
               s_d.seq = (s_q.seq == tgb_pkg::TGB_SEQ_AFE1) ?
                  tgb_pkg::TGB_SEQ_AFE2 : tgb_pkg::TGB_SEQ_DRAIN;
            end
            else if (push)
               s_d.idx = s_q.idx + 1'b1;
         end
         tgb_pkg::TGB_SEQ_DRAIN:
         begin
            if (empty && !s_q.busy && !s_q.closing && !pop)
            begin
               s_d.seq = tgb_pkg::TGB_SEQ_RUN;
               s_d.done = 1'b1;
            end
         end
         tgb_pkg::TGB_SEQ_RUN:
         begin
            if (rld_edge) // full rewrite, chain included
            begin
               s_d.seq = tgb_pkg::TGB_SEQ_START;
               s_d.done = 1'b0;
            end
         end
         default:
            s_d.seq = tgb_pkg::TGB_SEQ_START;
      endcase
      // buffer bookkeeping; a full buffer stalls the sequencer
      if (push)
      begin
         s_d.buf_mem[s_q.wp] = w;
         s_d.wp = ~s_q.wp;
      end
      if (pop)
         s_d.rp = ~s_q.rp;
      s_d.cnt = s_q.cnt + 2'(push) - 2'(pop);
      // serialiser: data set while clock low, taken on the rising edge
      if (pop)
      begin
         s_d.sh = s_q.buf_mem[s_q.rp].data;
         s_d.sdat = s_q.buf_mem[s_q.rp].data[tgb_pkg::WORD_BITS-1];
         s_d.last = s_q.buf_mem[s_q.rp].last;
         s_d.bit_cnt = tgb_pkg::BIT_CNT_BITS'(tgb_pkg::WORD_BITS - 1);
         s_d.half_cnt = '0;
         s_d.phase = 1'b0;
         s_d.busy = 1'b1;
         if (s_q.buf_mem[s_q.rp].first)
            s_d.strb_n = ~tgb_sel(s_q.buf_mem[s_q.rp].target);
      end
      else if (s_q.busy || s_q.closing)
      begin
         if (s_q.half_cnt ==
            tgb_pkg::SCK_CNT_BITS'(tgb_pkg::SCK_HALF_CYC - 1))
         begin
            s_d.half_cnt = '0;
            if (s_q.closing)
            begin
               s_d.closing = 1'b0;
               s_d.strb_n = 3'h7; // half a bit after the last fall
            end
            else if (!s_q.phase)
            begin
               s_d.sck = 1'b1;
               s_d.phase = 1'b1;
            end
            else
            begin
               s_d.sck = 1'b0;
               s_d.phase = 1'b0;
               if (s_q.bit_cnt == '0)
               begin
                  s_d.busy = 1'b0;
                  s_d.closing = s_q.last;
               end
               else
               begin
                  s_d.sh = {s_q.sh[tgb_pkg::WORD_BITS-2:0], 1'b0};
                  s_d.sdat = s_q.sh[tgb_pkg::WORD_BITS-2];
                  s_d.bit_cnt = s_q.bit_cnt - 1'b1;
               end
            end
         end
         else
            s_d.half_cnt = s_q.half_cnt + 1'b1;
      end
      // pixel clock: toggles every PIX_HALF_CYC cycles, so <= clk/2
      if (s_q.seq == tgb_pkg::TGB_SEQ_RUN)
      begin
         if (s_q.pix_cnt == tgb_pkg::PIX_CNT_BITS'(PIX_HALF_CYC - 1))
         begin
            s_d.pix_cnt = '0;
            s_d.pix = ~s_q.pix;
         end
         else
            s_d.pix_cnt = s_q.pix_cnt + 1'b1;
      end
      else
      begin
         s_d.pix_cnt = '0;
         s_d.pix = 1'b0;
      end
      // integration: whole tick periods in internal mode, held off outside run
      if (s_q.seq != tgb_pkg::TGB_SEQ_RUN)
      begin
         s_d.integ = 1'b0;
         s_d.int_cnt = '0;
      end
      else if (s_q.mode_s2)
         s_d.integ = s_q.gate_s2; // external mode follows the gate line
      else if (tick_edge) // one tick is one unit
      begin
         if (!s_q.integ) // limit ticks high, one tick low
         begin
            s_d.integ = 1'b1;
            s_d.int_cnt = '0;
         end
         else if (s_q.int_cnt == limit - 1'b1)
            s_d.integ = 1'b0;
         else
            s_d.int_cnt = s_q.int_cnt + 1'b1;
      end
   end
   // one register for all state; reset restarts the whole load
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         s_q <= '0;
         s_q.seq <= tgb_pkg::TGB_SEQ_START;
         s_q.strb_n <= 3'h7;
      end
      else if (i_ce)
         s_q <= s_d;
   end
   // outputs straight from the state register
   assign o_serial_shift_clock = s_q.sck;
   assign o_serial_shift_data = s_q.sdat;
   assign o_delay_chain_load_strobe_n = s_q.strb_n[tgb_pkg::TGB_TGT_DELAY];
   assign o_front_end_one_load_strobe_n = s_q.strb_n[tgb_pkg::TGB_TGT_AFE1];
   assign o_front_end_two_load_strobe_n = s_q.strb_n[tgb_pkg::TGB_TGT_AFE2];
   assign o_pixel_clock = s_q.pix;
   assign o_integrating = s_q.integ;
   assign o_init_done = s_q.done;
endmodule
`default_nettype wire

// [test/tgb_loader_sva.sv]
/* tgb_loader_sva: pin-level assertions for the serial loader.
   Assumes it is bound into tgb_loader and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module tgb_loader_sva
#(
   parameter int PIX_HALF_CYC = 1,
   parameter int INT_DEFAULT = 10
)
(
   // clock, reset, pins
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_ext_integration,
   input wire logic i_ext_gate,
   // serial and timing outputs
   input wire logic o_serial_shift_clock,
   input wire logic o_serial_shift_data,
   input wire logic o_delay_chain_load_strobe_n,
   input wire logic o_front_end_one_load_strobe_n,
   input wire logic o_front_end_two_load_strobe_n,
   input wire logic o_pixel_clock,
   input wire logic o_integrating,
   input wire logic o_init_done
);
   localparam int H1 = tgb_pkg::SCK_HALF_CYC - 1;
   wire logic [2:0] stb = {o_delay_chain_load_strobe_n,
      o_front_end_one_load_strobe_n, o_front_end_two_load_strobe_n};
   wire logic idle = &stb;
   wire logic sck = o_serial_shift_clock;
   logic pix_q;
   logic seen_q;
   logic [7:0] run_q;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   // pixel run length; first toggle of a run has no known phase, skip it
   // a low clock enable freezes the divider, so the run starts over
   always_ff @(posedge i_clk)
   begin
      if (i_rst || !o_init_done || !i_ce)
      begin
         seen_q <= 1'b0;
         run_q <= 8'h00;
      end
      else
      begin
         seen_q <= seen_q || (pix_q != o_pixel_clock);
         run_q <= (pix_q != o_pixel_clock) ? 8'h00 : run_q + 8'h01;
      end
      pix_q <= o_pixel_clock;
   end
   AST_RESET_IDLE: assert property ($fell(i_rst) |-> !sck && idle
      && !o_init_done && !o_pixel_clock) else $error("not idle after reset");
   AST_ONE_TARGET: assert property ($onehot0(~stb))
      else $error("two load strobes low");
   AST_NO_HOP: assert property (!idle && $past(!idle) |-> $stable(stb))
      else $error("strobe moved without gap");
   AST_SCK_FRAMED: assert property (sck |-> !idle)
      else $error("serial clock outside frame");
   AST_DATA_HOLD: assert property (sck |-> $stable(o_serial_shift_data))
      else $error("data moved while clock high");
   AST_SCK_HIGH: assert property ($rose(sck) |-> ##H1 sck ##1 !sck)
      else $error("serial clock high time wrong");
   AST_RUN_QUIET: assert property (o_init_done |-> idle && !sck)
      else $error("serial activity in run");
   AST_LOAD_FIRST: assert property (!idle |-> !o_pixel_clock)
      else $error("pixel clock during load");
   AST_PIX_HALF: assert property (o_init_done && seen_q |->
      run_q < PIX_HALF_CYC &&
      ((pix_q != o_pixel_clock) == (run_q == PIX_HALF_CYC - 1)))
      else $error("pixel half period wrong");
   AST_EXT_GATE: assert property (o_init_done && i_ext_integration
      && $past(i_ext_integration, 4) && $rose(i_ext_gate) |->
      ##[2:4] o_integrating) else $error("external gate not followed");
endmodule
bind tgb_loader tgb_loader_sva #(.PIX_HALF_CYC(PIX_HALF_CYC),
   .INT_DEFAULT(INT_DEFAULT)) tgb_loader_sva_inst
(
   .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
   .i_ext_integration(i_ext_integration),
   .i_ext_gate(i_ext_gate), .o_serial_shift_clock(o_serial_shift_clock),
   .o_serial_shift_data(o_serial_shift_data),
   .o_delay_chain_load_strobe_n(o_delay_chain_load_strobe_n),
   .o_front_end_one_load_strobe_n(o_front_end_one_load_strobe_n),
   .o_front_end_two_load_strobe_n(o_front_end_two_load_strobe_n),
   .o_pixel_clock(o_pixel_clock), .o_integrating(o_integrating),
   .o_init_done(o_init_done)
);
`default_nettype wire

// [test/tgb_serial_target.sv]
/* tgb_serial_target: delay chain and two front ends on the serial link.
   Assumes data is valid at the rising serial clock inside a strobe. */
`timescale 1ns/1ps
`default_nettype none
module tgb_serial_target
(
   // serial link
   input wire logic i_sck,
   input wire logic i_serial_shift_data,
   input wire logic i_dly_n,
   input wire logic i_fe1_n,
   input wire logic i_fe2_n,
   // captured images and counts
   output var logic [tgb_pkg::DLY_BITS-1:0] o_chain,
   output var logic [95:0] o_fe1,
   output var logic [95:0] o_fe2,
   output var int o_loads,
   output var int o_bad
);
   wire logic idle = i_dly_n & i_fe1_n & i_fe2_n; // three strobes
   logic [tgb_pkg::DLY_BITS-1:0] sh;
   int n = 0;
   int tgt = 3;
   initial o_loads = 0;
   initial o_bad = 0;
   // frame start picks the target; each rising clock shifts in one bit
   always @(negedge idle or posedge i_sck)
   begin
      if (i_sck)
      begin
         sh = {sh[tgb_pkg::DLY_BITS-2:0], i_serial_shift_data}; // msb first
         n = n + 1;
      end
      else
      begin
         n = 0;
         tgt = !i_fe1_n ? 1 : (!i_fe2_n ? 2 : 0);
      end
   end
   // strobe release commits the frame; a short one is counted as bad
   always @(posedge idle)
   begin
      if (tgt == 0)
      begin
         if (n != tgb_pkg::DLY_BITS) o_bad++;
         o_chain = sh; // first byte ends at the top
         o_loads++;
      end
      else if (tgt != 3 && n != 16) o_bad++;
      else if (tgt == 1) o_fe1[int'(sh[15:13])*12 +: 12] = sh[11:0];
      else if (tgt == 2) o_fe2[int'(sh[15:13])*12 +: 12] = sh[11:0];
   end
endmodule
`default_nettype wire

// [test/tgb_loader_tb.sv]
/* tgb_loader_tb: self-checking bench for the loader and its targets.
   Assumes package, loader, checker and target model compile first. */
`timescale 1ns/1ps
`default_nettype none
module tgb_loader_tb;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic ce = 1'b1;
   logic tick = 1'b0;
   logic ext = 1'b0;
   logic gate = 1'b0;
   logic [7:0] mult = 8'h00;
   logic reload = 1'b0;
   logic sck, sda, dly_n, fe1_n, fe2_n, pix, integ, done;
   logic [79:0] chain;
   logic [95:0] fe1, fe2;
   int loads, bad;
   int ticks = 0;
   int fail_count = 0;
   int comparisons = 0;
   // short pixel and integration counts keep the run brief
   tgb_loader #(.PIX_HALF_CYC(2), .INT_DEFAULT(3)) tgb_loader_inst
   (
      .i_clk(i_clk), .i_rst(i_rst), .i_ce(ce),
      .i_unit_integration_tick(tick), .i_ext_integration(ext),
      .i_ext_gate(gate), .i_int_mult(mult), .i_reload(reload),
      .o_serial_shift_clock(sck), .o_serial_shift_data(sda),
      .o_delay_chain_load_strobe_n(dly_n),
      .o_front_end_one_load_strobe_n(fe1_n),
      .o_front_end_two_load_strobe_n(fe2_n),
      .o_pixel_clock(pix), .o_integrating(integ), .o_init_done(done)
   );
   tgb_serial_target tgb_serial_target_inst
   (
      .i_sck(sck), .i_serial_shift_data(sda), .i_dly_n(dly_n), .i_fe1_n(fe1_n),
      .i_fe2_n(fe2_n), .o_chain(chain), .o_fe1(fe1), .o_fe2(fe2),
      .o_loads(loads), .o_bad(bad)
   );
   // clock, free tick oscillator of unrelated phase, tick counter
   always #2 i_clk = ~i_clk;
   always #62.5 tick = ~tick;
   always @(posedge tick) ticks++;
   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic chk(input string what, input logic [95:0] exp,
      input logic [95:0] got);
      comparisons++;
      if (got !== exp)
      begin
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
         fail_count++;
      end
   endtask
   task automatic wait_done;
      int k;
      for (k = 0; k < 30000 && done !== 1'b1; k++) step(1);
      chk("init done", 1'b1, done);
   endtask
   task automatic t_defaults;
      wait_done();
      chk("chain", tgb_pkg::DLY_DEFAULT, chain);
      chk("fe1", tgb_pkg::AFE1_DEFAULT, fe1);
      chk("fe2", tgb_pkg::AFE2_DEFAULT, fe2);
      chk("bad frames", 0, bad);
      $display("test defaults done");
   endtask
   task automatic t_pixel;
      int n;
      logic prev;
      n = 0;
      prev = pix;
      repeat (40)
      begin
         step(1);
         if (pix === 1'b1 && prev === 1'b0) n++;
         prev = pix;
      end
      chk("pixel rises", 10, n);
      // clock enable low must freeze the divider
      ce = 1'b0;
      step(7);
      chk("pixel frozen", prev, pix);
      ce = 1'b1;
      $display("test pixel done");
   endtask
   task automatic t_integ(input logic [7:0] m, input int nexp);
      int k;
      int t0;
      mult = m;
      for (k = 0; k < 2000 && integ !== 1'b1; k++) step(1);
      for (k = 0; k < 2000 && integ !== 1'b0; k++) step(1);
      for (k = 0; k < 2000 && integ !== 1'b1; k++) step(1);
      t0 = ticks;
      for (k = 0; k < 2000 && integ !== 1'b0; k++) step(1);
      chk("ticks high", nexp, ticks - t0);
      t0 = ticks;
      for (k = 0; k < 2000 && integ !== 1'b1; k++) step(1);
      chk("ticks low", 1, ticks - t0);
      $display("test integration done");
   endtask
   task automatic t_ext;
      ext = 1'b1;
      step(6);
      chk("gate low", 1'b0, integ);
      gate = 1'b1;
      step(5);
      chk("gate high", 1'b1, integ);
      gate = 1'b0;
      step(5);
      chk("gate low again", 1'b0, integ);
      ext = 1'b0;
      $display("test external done");
   endtask
   task automatic t_reload;
      int k;
      reload = 1'b1;
      step(5);
      reload = 1'b0;
      chk("run left", 1'b0, done);
      for (k = 0; k < 20000 && fe1_n !== 1'b0; k++) step(1);
      step(100);
      i_rst = 1'b1;
      step(12);
      chk("idle in reset", 4'hE, {dly_n, fe1_n, fe2_n, sck});
      i_rst = 1'b0;
      wait_done();
      chk("chain loads", 3, loads);
      chk("chain again", tgb_pkg::DLY_DEFAULT, chain);
      chk("fe1 again", tgb_pkg::AFE1_DEFAULT, fe1);
      chk("aborted frames", 1, bad);
      $display("test reload done");
   endtask
   task automatic close_out;
      $display("counts: %0d compared, %0d mismatched", comparisons,
         fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // watchdog: loads and tests take about 21,000 cycles; allow over twice that
   initial
   begin
      #200000;
      fail_count++;
      close_out();
   end
   initial
   begin
      step(12);
      i_rst = 1'b0;
      t_defaults();
      t_pixel();
      t_integ(8'h00, 3);
      t_integ(8'h05, 5);
      t_ext();
      t_reload();
      close_out();
   end
endmodule
`default_nettype wire
